/* hdl/trs_pkg.sv */
// Purpose: Shared constants and types for the two-breaker reclose sequencer
// Assumes: 50 MHz system clock, 1 ms scheme timebase
// Notes:   Failure action bit: 1 means lockout, 0 means continue
package trs_pkg;

  localparam int unsigned CLK_HZ      = 50_000_000;
  localparam int unsigned MS_PER_S    = 1000;
  localparam int unsigned TICK_MS     = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ / MS_PER_S * TICK_MS;
  localparam int          TW          = 16;

  typedef enum logic [2:0] {
    ORD_FIRST_ONLY,
    ORD_SECOND_ONLY,
    ORD_BOTH,
    ORD_FIRST_THEN_SECOND,
    ORD_SECOND_THEN_FIRST
  } trs_order_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RIP,
    ST_CLOSE_FIRST,
    ST_CLOSE_LAST,
    ST_LOCKOUT
  } trs_state_t;

  localparam logic [1:0] BRK_NONE   = 2'h0;
  localparam logic [1:0] BRK_FIRST  = 2'h1;
  localparam logic [1:0] BRK_SECOND = 2'h2;
  localparam logic [1:0] BRK_BOTH   = 2'h3;

  typedef struct packed {
    trs_order_t breaker_order;
    logic       transfer_first_to_second;
    logic       transfer_second_to_first;
    logic       first_breaker_failure_action;
    logic       second_breaker_failure_action;
  } trs_cfg_t;

  typedef struct packed {
    logic       initiate;
    logic       scheme_block_in;
    logic       cycle_hold_in;
    logic       first_breaker_inhibit;
    logic       second_breaker_inhibit;
    logic       scheme_reset;
    logic       manual_close;
    logic       protection_trip;
    logic [1:0] breaker_closed;
  } trs_pins_t;

  localparam trs_pins_t PINS_RST = '0;

endpackage

/* hdl/trs_ms_timer.sv */
// Purpose: Millisecond tick counter with compare against a programmed limit
// Assumes: tick is a one-cycle enable from the timebase divider
// Notes:   Saturates at the limit; a limit of zero is done at once
`timescale 1ns/1ps
`default_nettype none
module trs_ms_timer #(
  parameter int W = trs_pkg::TW
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         clr,
  input  wire logic         run,
  input  wire logic         tick,
  input  wire logic [W-1:0] limit,
  output logic              done
);

  logic [W-1:0] count_reg;

  assign done = (count_reg >= limit);

  always_ff @(posedge clk) begin
    if (rst || clr) begin
      count_reg <= '0;
    end else if (run && tick && !done) begin
      count_reg <= count_reg + 1'b1;
    end
  end

endmodule
`default_nettype wire

/* hdl/trs_sequencer.sv */
// Purpose: Reclose sequencer for two breakers after a line trip
// Assumes: Pins are asynchronous; cfg and timer limits are static settings
// Notes:   Summary of operation below
`timescale 1ns/1ps
`default_nettype none
module trs_sequencer #(
  parameter int unsigned TICK_CYCLES = trs_pkg::TICK_CYCLES,
  parameter int          TW          = trs_pkg::TW
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire trs_pkg::trs_cfg_t   cfg,
  input  wire logic [TW-1:0]       shot_timeout,
  input  wire logic [TW-1:0]       handover_delay,
  input  wire trs_pkg::trs_pins_t  pins,
  output logic [1:0]               breaker_close_cmd,
  output logic                     scheme_disabled_flag,
  output logic                     lockout_flag,
  output logic                     reclose_in_progress
);

  localparam int TCW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [TCW-1:0] TICK_LAST = TCW'(TICK_CYCLES - 1);

  trs_pkg::trs_pins_t  meta_reg;
  trs_pkg::trs_pins_t  p;
  trs_pkg::trs_state_t state_reg;
  trs_pkg::trs_state_t state_next;
  trs_pkg::trs_state_t rip_next;
  logic [1:0]          target_reg;
  logic [1:0]          target_next;
  logic [1:0]          rip_tgt;
  logic [TCW-1:0]      div_reg;
  logic                tick_reg;
  logic                shot_done;
  logic                ho_done;

  // Pins cross into the clock domain through two flops
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= trs_pkg::PINS_RST;
      p        <= trs_pkg::PINS_RST;
    end else begin
      meta_reg <= pins;
      p        <= meta_reg;
    end
  end

  // One millisecond timebase
  always_ff @(posedge clk) begin
    if (rst || div_reg == TICK_LAST) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (div_reg == TICK_LAST);
    end
  end

  wire first_ready  = !p.first_breaker_inhibit && !p.breaker_closed[0];
  wire second_ready = !p.second_breaker_inhibit && !p.breaker_closed[1];
  wire in_close     = (state_reg == trs_pkg::ST_CLOSE_FIRST) ||
                      (state_reg == trs_pkg::ST_CLOSE_LAST);
  wire target_made  = ((p.breaker_closed & target_reg) == target_reg);
  wire fail_lock    = (target_reg == trs_pkg::BRK_FIRST) ?
                      cfg.first_breaker_failure_action :
                      cfg.second_breaker_failure_action;
  wire next_close   = (state_next == trs_pkg::ST_CLOSE_FIRST) ||
                      (state_next == trs_pkg::ST_CLOSE_LAST);
  wire quiet        = !p.scheme_reset && !p.scheme_block_in &&
                      !p.cycle_hold_in;

  // Shot timer runs only in RECLOSE_IN_PROGRESS and is frozen by hold
  trs_ms_timer #(.W(TW)) u_shot (
    .clk   (clk),
    .rst   (rst),
    .clr   (state_reg != trs_pkg::ST_RIP),
    .run   (!p.cycle_hold_in),
    .tick  (tick_reg),
    .limit (shot_timeout),
    .done  (shot_done)
  );

  // Handover timer re-arms on every entry into a close state
  trs_ms_timer #(.W(TW)) u_handover (
    .clk   (clk),
    .rst   (rst),
    .clr   (state_reg != state_next),
    .run   (in_close && !p.cycle_hold_in),
    .tick  (tick_reg),
    .limit (handover_delay),
    .done  (ho_done)
  );

  // Breaker choice out of RECLOSE_IN_PROGRESS; waiting here lets the shot timer expire
  always_comb begin
    rip_next = trs_pkg::ST_RIP;
    rip_tgt  = trs_pkg::BRK_NONE;
    unique case (cfg.breaker_order)
      trs_pkg::ORD_FIRST_ONLY: begin
        if (first_ready) begin
          rip_next = trs_pkg::ST_CLOSE_LAST;
          rip_tgt  = trs_pkg::BRK_FIRST;
        end
      end
      trs_pkg::ORD_SECOND_ONLY: begin
        if (second_ready) begin
          rip_next = trs_pkg::ST_CLOSE_LAST;
          rip_tgt  = trs_pkg::BRK_SECOND;
        end
      end
      trs_pkg::ORD_BOTH: begin
        if (first_ready && second_ready) begin
          rip_next = trs_pkg::ST_CLOSE_LAST;
          rip_tgt  = trs_pkg::BRK_BOTH;
        end
      end
      trs_pkg::ORD_FIRST_THEN_SECOND: begin
        if (first_ready) begin
          rip_next = trs_pkg::ST_CLOSE_FIRST;
          rip_tgt  = trs_pkg::BRK_FIRST;
        end else if (p.first_breaker_inhibit && second_ready &&
                     cfg.transfer_first_to_second) begin
          rip_next = trs_pkg::ST_CLOSE_LAST;
          rip_tgt  = trs_pkg::BRK_SECOND;
        end
      end
      trs_pkg::ORD_SECOND_THEN_FIRST: begin
        if (second_ready) begin
          rip_next = trs_pkg::ST_CLOSE_FIRST;
          rip_tgt  = trs_pkg::BRK_SECOND;
        end else if (p.second_breaker_inhibit && first_ready &&
                     cfg.transfer_second_to_first) begin
          rip_next = trs_pkg::ST_CLOSE_LAST;
          rip_tgt  = trs_pkg::BRK_FIRST;
        end
      end
      default: begin
      end
    endcase
  end

  // Block outranks hold so a frozen cycle can still be abandoned
  always_comb begin
    state_next  = state_reg;
    target_next = target_reg;
    if (p.scheme_reset) begin
      state_next  = trs_pkg::ST_IDLE;
      target_next = trs_pkg::BRK_NONE;
    end else begin
      unique case (state_reg)
        trs_pkg::ST_IDLE: begin
          if (p.initiate && !p.scheme_block_in) begin
            state_next = trs_pkg::ST_RIP;
          end
        end
        trs_pkg::ST_RIP: begin
          if (p.scheme_block_in) begin
            state_next = trs_pkg::ST_LOCKOUT;
          end else if (p.cycle_hold_in) begin
            state_next = state_reg;
          end else if (shot_done) begin
            state_next = trs_pkg::ST_LOCKOUT;
          end else begin
            state_next  = rip_next;
            target_next = rip_tgt;
          end
        end
        trs_pkg::ST_CLOSE_FIRST: begin
          if (p.scheme_block_in || (!p.cycle_hold_in && p.protection_trip)) begin
            state_next = trs_pkg::ST_LOCKOUT;
          end else if (!p.cycle_hold_in && ho_done) begin
            if (target_made || !fail_lock) begin
              state_next  = trs_pkg::ST_CLOSE_LAST;
              target_next = ~target_reg;
            end else begin
              state_next = trs_pkg::ST_LOCKOUT;
            end
          end
        end
        trs_pkg::ST_CLOSE_LAST: begin
          if (p.scheme_block_in || (!p.cycle_hold_in && p.protection_trip)) begin
            state_next = trs_pkg::ST_LOCKOUT;
          end else if (!p.cycle_hold_in && target_made) begin
            state_next  = trs_pkg::ST_IDLE;
            target_next = trs_pkg::BRK_NONE;
          end else if (!p.cycle_hold_in && ho_done) begin
            state_next = trs_pkg::ST_LOCKOUT;
          end
        end
        trs_pkg::ST_LOCKOUT: begin
          if (p.manual_close) begin
            state_next  = trs_pkg::ST_IDLE;
            target_next = trs_pkg::BRK_NONE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg            <= trs_pkg::ST_IDLE;
      target_reg           <= trs_pkg::BRK_NONE;
      breaker_close_cmd    <= trs_pkg::BRK_NONE;
      scheme_disabled_flag <= 1'b0;
      lockout_flag         <= 1'b0;
      reclose_in_progress  <= 1'b0;
    end else begin
      state_reg            <= state_next;
      target_reg           <= target_next;
      breaker_close_cmd    <= next_close ? (target_next & ~p.breaker_closed)
                                         : trs_pkg::BRK_NONE;
      scheme_disabled_flag <= (state_next == trs_pkg::ST_IDLE) &&
                              p.scheme_block_in;
      lockout_flag         <= (state_next == trs_pkg::ST_LOCKOUT);
      reclose_in_progress  <= (state_next != trs_pkg::ST_IDLE) &&
                              (state_next != trs_pkg::ST_LOCKOUT);
    end
  end

  block_lockout_a: assert property (@(posedge clk) disable iff (rst)
    state_reg == trs_pkg::ST_RIP && p.scheme_block_in && !p.scheme_reset
    |=> state_reg == trs_pkg::ST_LOCKOUT && lockout_flag)
    else $error("block in RECLOSE_IN_PROGRESS did not lock out");

  block_disabled_a: assert property (@(posedge clk) disable iff (rst)
    state_reg == trs_pkg::ST_IDLE && p.scheme_block_in
    |=> scheme_disabled_flag && state_reg == trs_pkg::ST_IDLE)
    else $error("block before initiate did not disable");

  hold_freeze_a: assert property (@(posedge clk) disable iff (rst)
    p.cycle_hold_in && !p.scheme_reset && !p.scheme_block_in &&
    state_reg != trs_pkg::ST_LOCKOUT && state_reg != trs_pkg::ST_IDLE
    |=> state_reg == $past(state_reg) && $stable(breaker_close_cmd))
    else $error("hold did not freeze the cycle");

  shot_expiry_a: assert property (@(posedge clk) disable iff (rst)
    state_reg == trs_pkg::ST_RIP && shot_done && quiet
    |=> state_reg == trs_pkg::ST_LOCKOUT && breaker_close_cmd == 2'h0)
    else $error("shot timeout did not lock out");

  initiate_rip_a: assert property (@(posedge clk) disable iff (rst)
    state_reg == trs_pkg::ST_IDLE && p.initiate && quiet
    |=> reclose_in_progress && state_reg == trs_pkg::ST_RIP)
    else $error("initiate did not start a cycle");

  direct_second_a: assert property (@(posedge clk) disable iff (rst)
    state_reg == trs_pkg::ST_RIP && !shot_done && quiet &&
    cfg.breaker_order == trs_pkg::ORD_FIRST_THEN_SECOND &&
    p.first_breaker_inhibit && cfg.transfer_first_to_second && second_ready
    |=> breaker_close_cmd == trs_pkg::BRK_SECOND)
    else $error("inhibited first was not bypassed");

  fail_lockout_a: assert property (@(posedge clk) disable iff (rst)
    state_reg == trs_pkg::ST_CLOSE_FIRST && target_reg == trs_pkg::BRK_FIRST &&
    cfg.first_breaker_failure_action && ho_done && !p.breaker_closed[0] &&
    !p.protection_trip && quiet
    |=> state_reg == trs_pkg::ST_LOCKOUT ##1 breaker_close_cmd == 2'h0)
    else $error("failed first breaker did not lock out");

  handover_a: assert property (@(posedge clk) disable iff (rst)
    state_reg == trs_pkg::ST_CLOSE_FIRST && ho_done && target_made &&
    !p.protection_trip && quiet
    |=> state_reg == trs_pkg::ST_CLOSE_LAST && target_reg == ~$past(target_reg))
    else $error("close was not handed to second breaker");

  lockout_latch_a: assert property (@(posedge clk) disable iff (rst)
    state_reg == trs_pkg::ST_LOCKOUT && !p.scheme_reset && !p.manual_close
    |=> lockout_flag)
    else $error("lockout released without reset or manual close");

  close_level_a: assert property (@(posedge clk) disable iff (rst)
    breaker_close_cmd != 2'h0 |-> (state_reg == trs_pkg::ST_CLOSE_FIRST ||
    state_reg == trs_pkg::ST_CLOSE_LAST) && (breaker_close_cmd & ~target_reg) == 2'h0)
    else $error("close command outside a close state");

endmodule
`default_nettype wire

/* test/trs_breaker_model.sv */
// Purpose: Two breaker mechanisms with the line trip logic beside them
// Assumes: Close commands are levels from the sequencer
// Notes:   A breaker told to fail never closes, as a stuck mechanism would
`timescale 1ns/1ps
`default_nettype none
module trs_breaker_model #(
  parameter int CLOSE_CYC = 3
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [1:0] close_cmd,
  input  wire logic [1:0] fail_close,
  input  wire logic       trip,
  output logic      [1:0] closed
);
  int cnt [2];

  always_ff @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (rst || trip) begin
        closed[i] <= 1'b0; // Three-pole opening of both
        cnt[i]    <= 0;
      end else if (close_cmd[i] && !fail_close[i] && !closed[i]) begin
        cnt[i] <= cnt[i] + 1;
        if (cnt[i] == CLOSE_CYC - 1) begin
          closed[i] <= 1'b1;
        end
      end else begin
        cnt[i] <= 0;
      end
    end
  end
endmodule
`default_nettype wire

/* test/tb_trs_sequencer.sv */
// Purpose: Self-checking bench for the reclose sequencer
// Assumes: Short tick so each shot lasts tens of cycles
// Notes:   Outputs are watched as {close_cmd, disabled, lockout, rip}
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
  checked++; \
  if ((g) !== (e)) begin \
    errors++; \
    $display("unexpected %s: expected %h seen %h", nm, e, g); \
  end \
end
module tb_trs_sequencer;
  localparam int TICKS     = 4;
  localparam int LIMIT_CYC = 20000;
  logic               clk;
  logic               rst;
  trs_pkg::trs_cfg_t  cfg;
  trs_pkg::trs_pins_t pins;
  trs_pkg::trs_pins_t pins_in;
  logic [1:0]         fail_close;
  logic [1:0]         forbid;
  logic [1:0]         closed;
  logic [1:0]         breaker_close_cmd;
  logic               scheme_disabled_flag;
  logic               lockout_flag;
  logic               reclose_in_progress;
  logic [4:0]         outs;
  logic [1:0]         first;
  int                 mode;
  int                 errors;
  int                 checked;

  assign outs = {breaker_close_cmd, scheme_disabled_flag, lockout_flag,
                 reclose_in_progress};

  always_comb begin
    pins_in                = pins;
    pins_in.breaker_closed = closed;
  end

  // Shot window of 10 ticks outlasts any dead time used here
  trs_sequencer #(.TICK_CYCLES(TICKS), .TW(16)) DUT (
    .clk                  (clk),
    .rst                  (rst),
    .cfg                  (cfg),
    .shot_timeout         (16'h000A),
    .handover_delay       (16'h0006),
    .pins                 (pins_in),
    .breaker_close_cmd    (breaker_close_cmd),
    .scheme_disabled_flag (scheme_disabled_flag),
    .lockout_flag         (lockout_flag),
    .reclose_in_progress  (reclose_in_progress)
  );

  trs_breaker_model #(.CLOSE_CYC(3)) partner (
    .clk        (clk),
    .rst        (rst),
    .close_cmd  (breaker_close_cmd),
    .fail_close (fail_close),
    .trip       (pins.protection_trip),
    .closed     (closed)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // A close to a breaker that must stay untouched is caught at any edge
  always @(posedge clk) begin
    if ((breaker_close_cmd & forbid) !== 2'h0) begin
      errors++;
      $display("unexpected close_cmd: expected 0 seen %h",
               breaker_close_cmd & forbid);
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_out(input string nm, input logic [4:0] e,
                          input int lim);
    int i;
    i = 0;
    while (outs !== e && i < lim) begin
      step(1);
      i++;
    end
    `CHK(nm, e, outs)
  endtask

  // Scheme reset plus trip opens both breakers and idles the scheme, then settings load and initiate is pulsed once
  task automatic start(input logic [2:0] ord, input logic [3:0] opt,
                       input logic [1:0] inh, input logic [1:0] fl,
                       input logic [1:0] bh);
    pins.scheme_reset    = 1'b1;
    pins.protection_trip = 1'b1;
    step(2);
    pins = trs_pkg::PINS_RST;
    step(4);
    cfg                         = trs_pkg::trs_cfg_t'({ord, opt});
    fail_close                  = fl;
    pins.first_breaker_inhibit  = inh[0];
    pins.second_breaker_inhibit = inh[1];
    pins.scheme_block_in        = bh[0];
    pins.cycle_hold_in          = bh[1];
    step(4);
    pins.initiate = 1'b1;
    step(1);
    pins.initiate = 1'b0;
  endtask

  task automatic tdone(input string nm);
    $display("test %s done, mismatches so far %0d", nm, errors);
  endtask

  task automatic results;
    $display("comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #(LIMIT_CYC * 20);
    errors++;
    $display("unexpected run time: expected done seen running");
    results();
  end

  initial begin
    rst        = 1'b1;
    pins       = trs_pkg::PINS_RST;
    cfg        = trs_pkg::trs_cfg_t'(7'h00);
    fail_close = 2'h0;
    forbid     = 2'h0;
    errors     = 0;
    checked    = 0;
    step(4);
    rst = 1'b0;
    step(1);
    `CHK("outputs after reset", 5'h00, outs)
    start(3'h0, 4'h0, 2'h0, 2'h0, 2'h1);
    step(6);
    `CHK("disabled flag", 5'h04, outs)
    tdone("block before initiate");
    for (int k = 0; k < 3; k++) begin
      start(3'(k), 4'h0, 2'h0, 2'h0, 2'h0);
      wait_out("order close", {2'(k + 1), 3'h1}, 12);
      wait_out("idle after success", 5'h00, 20);
    end
    tdone("single orders");
    for (int k = 0; k < 6; k++) begin
      first  = (k < 3) ? 2'h1 : 2'h2;
      mode   = k % 3;
      forbid = (mode == 2) ? ~first : 2'h0;
      start((k < 3) ? 3'h3 : 3'h4, (mode == 2) ? 4'h3 : 4'h0, 2'h0,
            (mode == 0) ? 2'h0 : first, 2'h0);
      wait_out("first close", {first, 3'h1}, 12);
      step(12);
      `CHK("before handover", {(mode == 0) ? 2'h0 : first, 3'h1}, outs)
      if (mode < 2) begin
        wait_out("second close", {~first, 3'h1}, 30);
        wait_out("sequence reset", 5'h00, 20);
      end else begin
        wait_out("failure lockout", 5'h02, 30);
      end
      forbid = 2'h0;
    end
    tdone("sequential orders");
    start(3'h3, 4'h0, 2'h0, 2'h1, 2'h0);
    forbid = 2'h2;
    wait_out("first close", 5'h09, 12);
    pins.protection_trip = 1'b1;
    step(2);
    pins.protection_trip = 1'b0;
    wait_out("trip lockout", 5'h02, 8);
    step(30);
    `CHK("lockout latched", 5'h02, outs)
    forbid            = 2'h0;
    pins.manual_close = 1'b1;
    wait_out("manual release", 5'h00, 8);
    tdone("trip before handover");
    for (int k = 0; k < 2; k++) begin
      start(k ? 3'h4 : 3'h3, 4'hC, k ? 2'h2 : 2'h1, 2'h0, 2'h0);
      wait_out("direct transfer", k ? 5'h09 : 5'h11, 8);
      wait_out("transfer reset", 5'h00, 20);
      start(k ? 3'h4 : 3'h3, 4'h0, k ? 2'h2 : 2'h1, 2'h0, 2'h0);
      forbid = 2'h3;
      wait_out("in progress", 5'h01, 6);
      step(28);
      `CHK("before shot timeout", 5'h01, outs)
      wait_out("timeout lockout", 5'h02, 20);
      forbid            = 2'h0;
      pins.scheme_reset = 1'b1;
      wait_out("reset release", 5'h00, 8);
    end
    tdone("inhibited first breaker");
    start(3'h0, 4'h0, 2'h3, 2'h0, 2'h0);
    wait_out("in progress", 5'h01, 6);
    pins.scheme_block_in = 1'b1;
    wait_out("block lockout", 5'h02, 6);
    tdone("block in progress");
    start(3'h0, 4'h0, 2'h1, 2'h0, 2'h2);
    wait_out("in progress", 5'h01, 6);
    step(60);
    `CHK("frozen by hold", 5'h01, outs)
    pins.first_breaker_inhibit = 1'b0;
    step(8);
    `CHK("still frozen", 5'h01, outs)
    pins.cycle_hold_in = 1'b0;
    wait_out("resumed close", 5'h09, 8);
    wait_out("resumed reset", 5'h00, 20);
    tdone("hold");
    results();
  end
endmodule
`default_nettype wire
